// ==== irq_bank_pkg.sv ====
/*
  Constants shared by the interrupt flag, enable and priority bank:
  register word addresses, implemented-bit masks, reset values,
  priority field positions and priority codes.
  Assumes a 16-bit register port with a small word address.
*/
package irq_bank_pkg;

  // ==========================================================
  // Register port geometry
  localparam int          ADDR_W   = 4;
  localparam int          DATA_W   = 16;
  localparam logic [3:0]  OFF_FLAG = 4'h0;
  localparam logic [3:0]  OFF_EN   = 4'h1;
  localparam logic [3:0]  OFF_PRIO = 4'h2;

  // ==========================================================
  // Implemented bits and reset values
  // Flag/enable: bits 13..5 and 1..0
  localparam logic [15:0] SRC_MASK   = 16'h3FE3;
  // Priority: four 3-bit fields, bits 15/11/7/3 unused
  localparam logic [15:0] PRIO_MASK  = 16'h7777;
  localparam logic [15:0] FLAG_RST   = 16'h0000;
  localparam logic [15:0] EN_RST     = 16'h0000;
  // Each field comes up at code 100
  localparam logic [15:0] PRIO_RST   = 16'h4444;
  localparam logic [15:0] RDATA_IDLE = 16'h0000;

  // ==========================================================
  // Flag/enable bit positions
  localparam int BIT_PARPORT  = 13;
  localparam int BIT_CMP8     = 12;
  localparam int BIT_CMP5     = 9;
  localparam int BIT_CAP6     = 8;
  localparam int BIT_CAP3     = 5;
  localparam int BIT_SER2_EVT = 1;
  localparam int BIT_SER2_FLT = 0;

  // ==========================================================
  // Priority fields
  localparam int          PRIO_W        = 3;
  localparam int          LSB_PIN_CHG   = 12;
  localparam int          LSB_CMP       = 8;
  localparam int          LSB_TW_MASTER = 4;
  localparam int          LSB_TW_SLAVE  = 0;
  localparam logic [2:0]  PRIO_OFF      = 3'h0;
  localparam logic [2:0]  PRIO_LOW      = 3'h1;
  localparam logic [2:0]  PRIO_HIGH     = 3'h7;

endpackage

// ==== irq_flag_enable_priority_bank.sv ====
/*
  Interrupt flag-status, enable and priority bank for one group of
  peripheral sources, with the gating that forwards requests to the
  core arbiter and a registered 16-bit software register port.
  Assumes source events are synchronous one-cycle pulses on core_clk
  and that the arbiter samples registered request and level outputs.
*/

// How it works
// - A flag reads 1 after its source requests, 0 when none occurred.
// - Enable 1 lets the flagged request out; enable 0 blocks it.
// - Priority code 111 is level 7, the highest.
// - Priority code 000 disables the source regardless of its enable.
// - Code 001 is level 1; codes between map linearly to 2..6.
// - Compare channel 8..5 flags sit at bits 12..9.
// - Compare channel 8..5 enables sit at bits 12..9.
// - Capture channel 6..3 flags sit at bits 8..5.
// - Capture channel 6..3 enables sit at bits 8..5.
// - Pin-change priority is bits 14..12; bit 15 unused.
// - Comparator priority is bits 10..8; bit 11 unused.
// - Two-wire master priority bits 6..4, slave 2..0; 7, 3 unused.
module irq_flag_enable_priority_bank (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] source_event,
  input  wire logic        pin_change_req,
  input  wire logic        comparator_req,
  input  wire logic        twowire_master_req,
  input  wire logic        twowire_slave_req,
  output logic      [15:0] fwd_req,
  output logic             pin_change_fwd,
  output logic             comparator_fwd,
  output logic             twowire_master_fwd,
  output logic             twowire_slave_fwd,
  output logic      [2:0]  pin_change_level,
  output logic      [2:0]  comparator_level,
  output logic      [2:0]  twowire_master_level,
  output logic      [2:0]  twowire_slave_level,
  output logic      [2:0]  top_level
);

  // ==========================================================
  // Storage
  logic [15:0] irq_flag_status_2;
  logic [15:0] irq_enable_control_2;
  logic [15:0] irq_priority_change_cmp_i2c;
  logic [2:0]  pin_change_prio;
  logic [2:0]  comparator_prio;
  logic [2:0]  twowire_master_prio;
  logic [2:0]  twowire_slave_prio;
  logic [15:0] next_flag;
  logic [15:0] event_in;
  logic        wr_flag;
  logic        wr_en;
  logic        wr_prio;

  // Level of a priority code; the code is the level, 000 means off
  function automatic logic [2:0] level_of(input logic [2:0] code,
                                          input logic       req);
    level_of = req ? code : irq_bank_pkg::PRIO_OFF;
  endfunction

  // Higher of two levels
  function automatic logic [2:0] max_level(input logic [2:0] a,
                                           input logic [2:0] b);
    max_level = (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Write decode
  assign wr_flag = reg_wr && (reg_addr == irq_bank_pkg::OFF_FLAG);
  assign wr_en   = reg_wr && (reg_addr == irq_bank_pkg::OFF_EN);
  assign wr_prio = reg_wr && (reg_addr == irq_bank_pkg::OFF_PRIO);

  // Priority fields sliced from the priority register
  assign pin_change_prio     = irq_priority_change_cmp_i2c[
    irq_bank_pkg::LSB_PIN_CHG +: irq_bank_pkg::PRIO_W];
  assign comparator_prio     = irq_priority_change_cmp_i2c[
    irq_bank_pkg::LSB_CMP +: irq_bank_pkg::PRIO_W];
  assign twowire_master_prio = irq_priority_change_cmp_i2c[
    irq_bank_pkg::LSB_TW_MASTER +: irq_bank_pkg::PRIO_W];
  assign twowire_slave_prio  = irq_priority_change_cmp_i2c[
    irq_bank_pkg::LSB_TW_SLAVE +: irq_bank_pkg::PRIO_W];

  // ==========================================================
  // Flags: hardware set beats a software clear in the same cycle,
  // so an event coinciding with a clear is never lost
  always_comb begin
    event_in  = source_event & irq_bank_pkg::SRC_MASK;
    next_flag = irq_flag_status_2;
    if (wr_flag) begin
      next_flag = reg_wdata & irq_bank_pkg::SRC_MASK;
    end
    next_flag = next_flag | event_in;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_flag_status_2 <= irq_bank_pkg::FLAG_RST;
    end else begin
      irq_flag_status_2 <= next_flag;
    end
  end

  // Enables mirror the flag layout
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_enable_control_2 <= irq_bank_pkg::EN_RST;
    end else if (wr_en) begin
      irq_enable_control_2 <= reg_wdata & irq_bank_pkg::SRC_MASK;
    end
  end

  // Priority register; unused bits 15/11/7/3 never store
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_priority_change_cmp_i2c <= irq_bank_pkg::PRIO_RST;
    end else if (wr_prio) begin
      irq_priority_change_cmp_i2c <= reg_wdata & irq_bank_pkg::PRIO_MASK;
    end
  end

  // ==========================================================
  // Read port: data stands only in the cycle after the strobe,
  // zero otherwise and for unmapped addresses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= irq_bank_pkg::RDATA_IDLE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        irq_bank_pkg::OFF_FLAG: reg_rdata <= irq_flag_status_2;
        irq_bank_pkg::OFF_EN:   reg_rdata <= irq_enable_control_2;
        irq_bank_pkg::OFF_PRIO: reg_rdata <= irq_priority_change_cmp_i2c;
        default:                reg_rdata <= irq_bank_pkg::RDATA_IDLE;
      endcase
    end else begin
      reg_rdata <= irq_bank_pkg::RDATA_IDLE;
    end
  end

  // ==========================================================
  // Forwarding of the flag group: flag and enable both needed.
  // Their priorities live in other registers, so the arbiter
  // applies the non-zero check for these.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fwd_req <= irq_bank_pkg::FLAG_RST;
    end else begin
      fwd_req <= irq_flag_status_2 & irq_enable_control_2;
    end
  end

  // Prioritised sources: a zero code blocks the request outright
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_change_fwd     <= 1'b0;
      comparator_fwd     <= 1'b0;
      twowire_master_fwd <= 1'b0;
      twowire_slave_fwd  <= 1'b0;
    end else begin
      pin_change_fwd     <= pin_change_req && (pin_change_prio != irq_bank_pkg::PRIO_OFF);
      comparator_fwd     <= comparator_req && (comparator_prio != irq_bank_pkg::PRIO_OFF);
      twowire_master_fwd <= twowire_master_req &&
                            (twowire_master_prio != irq_bank_pkg::PRIO_OFF);
      twowire_slave_fwd  <= twowire_slave_req &&
                            (twowire_slave_prio != irq_bank_pkg::PRIO_OFF);
    end
  end

  // Levels travel with the request; zero while not requesting
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_change_level     <= irq_bank_pkg::PRIO_OFF;
      comparator_level     <= irq_bank_pkg::PRIO_OFF;
      twowire_master_level <= irq_bank_pkg::PRIO_OFF;
      twowire_slave_level  <= irq_bank_pkg::PRIO_OFF;
      top_level            <= irq_bank_pkg::PRIO_OFF;
    end else begin
      pin_change_level     <= level_of(pin_change_prio, pin_change_req);
      comparator_level     <= level_of(comparator_prio, comparator_req);
      twowire_master_level <= level_of(twowire_master_prio, twowire_master_req);
      twowire_slave_level  <= level_of(twowire_slave_prio, twowire_slave_req);
      // Highest pending level among the four, for the arbiter
      top_level <= max_level(
        max_level(level_of(pin_change_prio, pin_change_req),
                  level_of(comparator_prio, comparator_req)),
        max_level(level_of(twowire_master_prio, twowire_master_req),
                  level_of(twowire_slave_prio, twowire_slave_req)));
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence rd_prio_s;
    reg_rd && (reg_addr == irq_bank_pkg::OFF_PRIO);
  endsequence

  sequence idle_bus_s;
    !reg_rd;
  endsequence

  // Any event leaves its flag set on the next edge
  flag_set_a: assert property (
    (event_in != 16'h0000) |=>
      ((irq_flag_status_2 & $past(event_in)) == $past(event_in)))
    else $error("event did not set its flag");

  // No event and no write: every flag keeps its value
  flag_hold_a: assert property (
    (!wr_flag && event_in == 16'h0000) |=>
      (irq_flag_status_2 == $past(irq_flag_status_2)))
    else $error("flag changed without cause");

  // Unused positions stay zero everywhere
  unused_zero_a: assert property (
    ((irq_flag_status_2 & ~irq_bank_pkg::SRC_MASK) == 16'h0000) &&
    ((irq_enable_control_2 & ~irq_bank_pkg::SRC_MASK) == 16'h0000) &&
    ((irq_priority_change_cmp_i2c & ~irq_bank_pkg::PRIO_MASK) == 16'h0000))
    else $error("unused bit became set");

  // Forwarded flags follow flag and enable one edge on
  fwd_gate_a: assert property (
    ##1 (fwd_req == $past(irq_flag_status_2 & irq_enable_control_2)))
    else $error("forwarded request mismatch");

  // Zero priority blocks the request for that source
  prio_off_a: assert property (
    (comparator_prio == irq_bank_pkg::PRIO_OFF) |=>
      (!comparator_fwd && comparator_level == irq_bank_pkg::PRIO_OFF))
    else $error("disabled source forwarded");

  // Code 111 with a request gives top level 7
  level_max_a: assert property (
    (pin_change_req && pin_change_prio == irq_bank_pkg::PRIO_HIGH) |=>
      (pin_change_level == irq_bank_pkg::PRIO_HIGH && top_level == irq_bank_pkg::PRIO_HIGH))
    else $error("code 111 not level 7");

  // Forwarded level equals the code held one edge before
  level_lin_a: assert property (
    twowire_slave_fwd |-> (twowire_slave_level == $past(twowire_slave_prio)))
    else $error("level not equal to code");

  // Priority readback in the next cycle only, then zero
  prio_read_a: assert property (
    rd_prio_s ##1 idle_bus_s |->
      ($past(reg_rd) && reg_rdata == $past(irq_priority_change_cmp_i2c)) ##1
      (reg_rdata == irq_bank_pkg::RDATA_IDLE))
    else $error("priority readback wrong");

  // Enable write stores only the implemented bits
  en_write_a: assert property (
    wr_en |=> (irq_enable_control_2 == ($past(reg_wdata) & irq_bank_pkg::SRC_MASK)))
    else $error("enable write mismatch");

  sequence rd_flag_s;
    reg_rd && (reg_addr == irq_bank_pkg::OFF_FLAG);
  endsequence

  sequence rd_en_s;
    reg_rd && (reg_addr == irq_bank_pkg::OFF_EN);
  endsequence

  // Flag readback lands in the cycle after the strobe
  flag_read_a: assert property (
    rd_flag_s |=> (reg_rdata == $past(irq_flag_status_2)))
    else $error("flag readback wrong");

  // Enable readback lands in the cycle after the strobe
  en_read_a: assert property (
    rd_en_s |=> (reg_rdata == $past(irq_enable_control_2)))
    else $error("enable readback wrong");

  // Zero outside the read cycle keeps stale words off a shared read mux
  rdata_idle_a: assert property (
    !reg_rd |=> (reg_rdata == irq_bank_pkg::RDATA_IDLE))
    else $error("read data outside its cycle");

  // Reads beyond the last register return zero
  unmapped_read_a: assert property (
    (reg_rd && reg_addr > irq_bank_pkg::OFF_PRIO) |=>
      (reg_rdata == irq_bank_pkg::RDATA_IDLE))
    else $error("unmapped read not zero");

  // A write with no coinciding event leaves exactly the written implemented bits
  flag_write_a: assert property (
    (wr_flag && event_in == 16'h0000) |=>
      (irq_flag_status_2 == ($past(reg_wdata) & irq_bank_pkg::SRC_MASK)))
    else $error("flag write mismatch");

  // Priority write keeps only the four fields
  prio_write_a: assert property (
    wr_prio |=>
      (irq_priority_change_cmp_i2c == ($past(reg_wdata) & irq_bank_pkg::PRIO_MASK)))
    else $error("priority write mismatch");

  // Enables change only through a write
  en_hold_a: assert property (
    !wr_en |=> $stable(irq_enable_control_2))
    else $error("enable changed without a write");

  // Zero code blocks the pin-change request as well
  pin_off_a: assert property (
    (pin_change_prio == irq_bank_pkg::PRIO_OFF) |=>
      (!pin_change_fwd && pin_change_level == irq_bank_pkg::PRIO_OFF))
    else $error("disabled pin-change source forwarded");

  // Zero codes block both two-wire requests
  tw_off_a: assert property (
    (twowire_master_prio == irq_bank_pkg::PRIO_OFF &&
     twowire_slave_prio == irq_bank_pkg::PRIO_OFF) |=>
      (!twowire_master_fwd && !twowire_slave_fwd))
    else $error("disabled two-wire source forwarded");

  // A forwarded request always carries a non-zero level
  fwd_level_a: assert property (
    comparator_fwd |-> (comparator_level != irq_bank_pkg::PRIO_OFF))
    else $error("forwarded without a level");

  // A dropped request gives level zero on the next edge
  level_drop_a: assert property (
    !twowire_slave_req |=> (twowire_slave_level == irq_bank_pkg::PRIO_OFF))
    else $error("level without a request");

  // Code 001 is the lowest active level
  level_low_a: assert property (
    (comparator_req && comparator_prio == irq_bank_pkg::PRIO_LOW) |=>
      (comparator_fwd && comparator_level == irq_bank_pkg::PRIO_LOW))
    else $error("code 001 not level 1");

  // Top level never falls below any single requesting level
  top_level_a: assert property (
    (top_level >= pin_change_level) && (top_level >= comparator_level) &&
    (top_level >= twowire_master_level) && (top_level >= twowire_slave_level))
    else $error("top level below a requester");

endmodule

// ==== irq_flag_enable_priority_bank_tb.sv ====
/*
  Self-checking bench for the interrupt flag, enable and priority bank.
  Assumes the bank's package and an event source model alongside.
*/
module irq_flag_enable_priority_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, fire = 16'h0000, source_event, reg_rdata, fwd_req, d;
  logic pin_change_req = 1'b0, comparator_req = 1'b0;
  logic twowire_master_req = 1'b0, twowire_slave_req = 1'b0;
  logic pin_change_fwd, comparator_fwd, twowire_master_fwd, twowire_slave_fwd;
  logic [2:0] pin_change_level, comparator_level, twowire_master_level;
  logic [2:0] twowire_slave_level, top_level, code;
  int n_fail = 0, checks_done = 0;
  // Rows: event, enable, expected flags, expected forwarded requests
  logic [15:0] r_ev[7]   = '{16'h2000, 16'h1000, 16'h0200, 16'h0100, 16'h0020, 16'h0003, 16'hC01C};
  logic [15:0] r_en[7]   = '{16'h3FE3, 16'h1000, 16'h0000, 16'h0100, 16'h3FE3, 16'h0001, 16'h3FE3};
  logic [15:0] r_flag[7] = '{16'h2000, 16'h1000, 16'h0200, 16'h0100, 16'h0020, 16'h0003, 16'h0000};
  logic [15:0] r_fwd[7]  = '{16'h2000, 16'h1000, 16'h0000, 16'h0100, 16'h0020, 16'h0001, 16'h0000};

  always #2 core_clk = ~core_clk;

  irq_src_model irq_src_model_inst (.core_clk(core_clk), .rst(rst), .fire(fire),
    .source_event(source_event));

  irq_flag_enable_priority_bank irq_flag_enable_priority_bank_inst (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_event(source_event),
    .pin_change_req(pin_change_req), .comparator_req(comparator_req),
    .twowire_master_req(twowire_master_req), .twowire_slave_req(twowire_slave_req),
    .fwd_req(fwd_req), .pin_change_fwd(pin_change_fwd), .comparator_fwd(comparator_fwd),
    .twowire_master_fwd(twowire_master_fwd), .twowire_slave_fwd(twowire_slave_fwd),
    .pin_change_level(pin_change_level), .comparator_level(comparator_level),
    .twowire_master_level(twowire_master_level),
    .twowire_slave_level(twowire_slave_level), .top_level(top_level));

  // ==========================================
  // Register port and compare helpers
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(irq_bank_pkg::OFF_FLAG, d); chk(d, 16'h0000);
    rd(irq_bank_pkg::OFF_PRIO, d); chk(d, 16'h4444);
    // Unused bits and unmapped places drop writes
    wr(irq_bank_pkg::OFF_EN, 16'hFFFF);
    rd(irq_bank_pkg::OFF_EN, d); chk(d, 16'h3FE3);
    wr(irq_bank_pkg::OFF_PRIO, 16'hFFFF);
    rd(irq_bank_pkg::OFF_PRIO, d); chk(d, 16'h7777);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, d); chk(d, 16'h0000);
    // Flag and enable rows
    for (int i = 0; i < 7; i++) begin
      wr(irq_bank_pkg::OFF_FLAG, 16'h0000);
      wr(irq_bank_pkg::OFF_EN, r_en[i]);
      fire <= r_ev[i];
      @(posedge core_clk);
      fire <= 16'h0000;
      repeat (3) @(posedge core_clk);
      #1 chk(fwd_req, r_fwd[i]);
      rd(irq_bank_pkg::OFF_FLAG, d); chk(d, r_flag[i]);
    end
    wr(irq_bank_pkg::OFF_FLAG, 16'h0000);
    rd(irq_bank_pkg::OFF_FLAG, d); chk(d, 16'h0000);
    // Every priority code in every field, all requests up
    @(posedge core_clk);
    pin_change_req <= 1'b1;
    comparator_req <= 1'b1;
    twowire_master_req <= 1'b1;
    twowire_slave_req <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      code = c[2:0];
      wr(irq_bank_pkg::OFF_PRIO, {1'b0, code, 1'b0, code, 1'b0, code, 1'b0, code});
      repeat (2) @(posedge core_clk);
      #1 chk(16'(comparator_level), 16'(code));
      chk(16'(pin_change_level), 16'(code));
      chk(16'(twowire_master_level), 16'(code));
      chk(16'(twowire_slave_level), 16'(code));
      chk(16'(comparator_fwd), 16'(code != 3'h0));
      chk(16'(twowire_slave_fwd), 16'(code != 3'h0));
      chk(16'(pin_change_fwd), 16'(code != 3'h0));
      chk(16'(twowire_master_fwd), 16'(code != 3'h0));
      chk(16'(top_level), 16'(code));
    end
    // Distinct fields: highest requester wins, dropped request clears its level
    wr(irq_bank_pkg::OFF_PRIO, 16'h1357);
    twowire_slave_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(16'(top_level), 16'h0005);
    chk(16'(twowire_slave_level), 16'h0000);
    chk(16'(pin_change_level), 16'h0001);
    chk(16'(twowire_slave_fwd), 16'h0000);
    chk(16'(twowire_master_fwd), 16'h0001);
    // Clear and event in one cycle: the event must win
    @(posedge core_clk);
    fire <= 16'h0002;
    @(posedge core_clk);
    fire <= 16'h0000;
    reg_addr <= irq_bank_pkg::OFF_FLAG;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    rd(irq_bank_pkg::OFF_FLAG, d); chk(d, 16'h0002);
    // Software may set flags; unused bits stay clear; data stands one cycle
    wr(irq_bank_pkg::OFF_FLAG, 16'hFFFF);
    rd(irq_bank_pkg::OFF_FLAG, d); chk(d, 16'h3FE3);
    chk(fwd_req, 16'h3FE3);
    @(posedge core_clk);
    #1 chk(reg_rdata, 16'h0000);
    // Mid-run reset: registers and outputs return to reset values
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(fwd_req, 16'h0000);
    chk(16'(top_level), 16'h0000);
    chk(16'(pin_change_fwd), 16'h0000);
    @(posedge core_clk);
    rst <= 1'b0;
    rd(irq_bank_pkg::OFF_FLAG, d); chk(d, 16'h0000);
    rd(irq_bank_pkg::OFF_EN, d); chk(d, 16'h0000);
    rd(irq_bank_pkg::OFF_PRIO, d); chk(d, 16'h4444);
    chk(16'(top_level), 16'h0004);
    finish_test();
  end
endmodule

// ==== irq_src_model.sv ====
/*
  Peripheral event source model for the interrupt bank.
  Assumes the bench asks for events one cycle ahead on core_clk.
*/
module irq_src_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] fire,
  output logic      [15:0] source_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Event pulses
  // Registered so events leave just after an edge, like real peripherals
  always_ff @(posedge core_clk) begin
    source_event <= rst ? 16'h0000 : fire;
  end
endmodule
